// ---- logic/sapmc_ctrl.sv ----
// sapmc_ctrl: frame and power-mode control of a serial sampling converter
// assumes: chip select and serial clock are synchronous to the core clock,
// the serial clock is slow enough that each level lasts two core cycles,
// and the sampled result is stable on i_conv_result when chip select falls
//
// Behaviour
// - rise after tenth edge: normal, abort word
// - sixteen clocks read a word, then idle
// - output released after sixteenth falling edge
// - rise between second and tenth: shutdown
// - rise before second edge keeps mode
// - wake from shutdown; first result is dummy
// - woken frame aborted early returns to shutdown
// - fully powered after sixteen clocks
// - power-on mode unknown (reset here loads shutdown); dummy conversion first
// - shutdown turns analog off until select low
// - three zeros, ten bits msb first, three zeros
// - select fall drives output and samples input
`timescale 1ns/1ps
`default_nettype none
`include "sapmc_map.svh"

module sapmc_ctrl (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // serial link from the host
  input wire logic i_chip_sel_n,
  input wire logic i_serial_clk,
  output var sapmc_pkg::sapmc_sdo_t o_serial_data_out,
  // converter core
  input wire logic [`SAPMC_RESULT_BITS-1:0] i_conv_result,
  output logic o_sample_now,
  output logic o_analog_en,
  // status
  output logic o_mode_normal,
  output logic o_powered_up,
  output logic o_result_valid,
  output logic [`SAPMC_CNT_BITS-1:0] o_edge_count
);

  sapmc_pkg::sapmc_state_t q;
  sapmc_pkg::sapmc_state_t d;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic edge_step;
  logic [`SAPMC_CNT_BITS-1:0] cnt;

  // ****************************************************************
  // pin events
  // ****************************************************************
  // new frame only on select falling
  assign cs_fall = q.cs_n_q & ~i_chip_sel_n;
  assign cs_rise = ~q.cs_n_q & i_chip_sel_n;
  assign sclk_fall = q.sclk_q & ~i_serial_clk;
  // edges after a select rise in the same cycle are not counted
  assign edge_step = sclk_fall & (q.phase == sapmc_pkg::SAPMC_SHIFT) & ~cs_rise;

  // ****************************************************************
  // falling-edge counter
  // ****************************************************************
  sapmc_edge_cnt #(
    .SAT_EDGES(`SAPMC_EDGE_SAT)
  ) u_edge_cnt (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(cs_fall),
    .i_step(edge_step),
    .o_count(cnt)
  );

  // mode chosen when select rises mid-frame
  function automatic sapmc_pkg::sapmc_mode_t mode_on_rise(
    input logic [`SAPMC_CNT_BITS-1:0] edges,
    input sapmc_pkg::sapmc_mode_t now
  );
    sapmc_pkg::sapmc_mode_t m;
    if (edges < `SAPMC_EDGE_GLITCH) begin
      m = now;
    end else if (edges < `SAPMC_EDGE_MODE) begin
      m = sapmc_pkg::SAPMC_SHUTDOWN;
    end else begin
      m = sapmc_pkg::SAPMC_NORMAL;
    end
    return m;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.sclk_q = i_serial_clk;
    d.cs_n_q = i_chip_sel_n;
    unique case (q.phase)
      sapmc_pkg::SAPMC_IDLE: begin
        if (cs_fall) begin
          d.phase = sapmc_pkg::SAPMC_SHIFT;
          d.oe = 1'b1;
          d.shreg = {`SAPMC_LEAD_ZEROS, i_conv_result, `SAPMC_TAIL_ZEROS};
          // wake-up frame yields a dummy result
          d.from_sd = (q.mode == sapmc_pkg::SAPMC_SHUTDOWN);
          d.valid = ~q.dummy & (q.mode == sapmc_pkg::SAPMC_NORMAL);
        end
      end
      sapmc_pkg::SAPMC_SHIFT: begin
        if (cs_rise) begin
          d.phase = sapmc_pkg::SAPMC_IDLE;
          d.oe = 1'b0;
          d.valid = 1'b0;
          d.from_sd = 1'b0;
          d.mode = mode_on_rise(cnt, q.mode);
          if (d.mode == sapmc_pkg::SAPMC_SHUTDOWN) begin
            d.dummy = 1'b1;
            d.powered = 1'b0;
          end
        end else if (sclk_fall) begin
          if (cnt == `SAPMC_EDGE_LAST) begin
            d.phase = sapmc_pkg::SAPMC_DONE;
            d.oe = 1'b0;
            d.mode = sapmc_pkg::SAPMC_NORMAL;
            d.powered = 1'b1;
            d.dummy = 1'b0;
            d.from_sd = 1'b0;
          end else begin
            d.shreg = {q.shreg[`SAPMC_FRAME_BITS-2:0], 1'b0};
          end
        end
      end
      sapmc_pkg::SAPMC_DONE: begin
        // select may idle low; wait for its rise
        if (cs_rise) begin
          d.phase = sapmc_pkg::SAPMC_IDLE;
          d.valid = 1'b0;
        end
      end
      default: begin
        d.phase = sapmc_pkg::SAPMC_IDLE;
        d.oe = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // power-on mode is a fixed choice; first frame is dummy
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.sclk_q <= `SAPMC_RST_HIGH;
      q.cs_n_q <= `SAPMC_RST_HIGH;
      q.phase <= sapmc_pkg::SAPMC_IDLE;
      q.mode <= `SAPMC_RST_MODE;
      q.dummy <= `SAPMC_RST_HIGH;
      q.powered <= `SAPMC_RST_LOW;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // data bit first, enable second, as the struct lays them out
  assign o_serial_data_out = {q.shreg[`SAPMC_FRAME_BITS-1], q.oe};
  assign o_sample_now = cs_fall;
  // analog on only in normal mode or within a frame
  assign o_analog_en = (q.mode == sapmc_pkg::SAPMC_NORMAL) | (q.phase != sapmc_pkg::SAPMC_IDLE);
  assign o_mode_normal = (q.mode == sapmc_pkg::SAPMC_NORMAL);
  assign o_powered_up = q.powered;
  assign o_result_valid = q.valid;
  assign o_edge_count = cnt;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_start_drive;
    cs_fall && (q.phase == sapmc_pkg::SAPMC_IDLE) |=> o_serial_data_out.oe ##0
      !o_serial_data_out.data ##0 (cnt == `SAPMC_CNT_ZERO);
  endproperty
  a_start_drive: assert property (p_start_drive) else $error("frame start not driven");

  property p_lead_zeros;
    (q.phase == sapmc_pkg::SAPMC_SHIFT) && (cnt < `SAPMC_EDGE_DATA) |-> !o_serial_data_out.data;
  endproperty
  a_lead_zeros: assert property (p_lead_zeros) else $error("leading bit not zero");

  property p_release_16;
    edge_step && (cnt == `SAPMC_EDGE_LAST) |=> !o_serial_data_out.oe ##1
      (!o_serial_data_out.oe || (cnt == `SAPMC_CNT_ZERO));
  endproperty
  a_release_16: assert property (p_release_16) else $error("output held after word");

  property p_abort_normal;
    cs_rise && (q.phase == sapmc_pkg::SAPMC_SHIFT) && (cnt >= `SAPMC_EDGE_MODE)
      |=> !o_serial_data_out.oe && o_mode_normal;
  endproperty
  a_abort_normal: assert property (p_abort_normal) else $error("late abort left normal");

  property p_enter_sd;
    cs_rise && (q.phase == sapmc_pkg::SAPMC_SHIFT) && (cnt >= `SAPMC_EDGE_GLITCH)
      && (cnt < `SAPMC_EDGE_MODE) |=> !o_mode_normal && !o_serial_data_out.oe && !o_analog_en;
  endproperty
  a_enter_sd: assert property (p_enter_sd) else $error("shutdown not entered");

  property p_glitch_keep;
    cs_rise && (q.phase == sapmc_pkg::SAPMC_SHIFT) && (cnt < `SAPMC_EDGE_GLITCH)
      |=> (o_mode_normal == $past(o_mode_normal));
  endproperty
  a_glitch_keep: assert property (p_glitch_keep) else $error("glitch changed mode");

  property p_wake_abort;
    cs_rise && q.from_sd && (q.phase == sapmc_pkg::SAPMC_SHIFT) && (cnt < `SAPMC_EDGE_MODE)
      |=> !o_mode_normal;
  endproperty
  a_wake_abort: assert property (p_wake_abort) else $error("woken frame stayed normal");

  property p_wake_dummy;
    cs_fall && !o_mode_normal |=> o_analog_en && !o_result_valid && !o_powered_up;
  endproperty
  a_wake_dummy: assert property (p_wake_dummy) else $error("wake frame not dummy");

  property p_powered;
    edge_step && q.from_sd && (cnt == `SAPMC_EDGE_LAST) |=> o_powered_up && o_mode_normal;
  endproperty
  a_powered: assert property (p_powered) else $error("not powered after sixteen");

  property p_sd_hold;
    (!o_mode_normal && (q.phase == sapmc_pkg::SAPMC_IDLE) && i_chip_sel_n) ##1 i_chip_sel_n
      |-> !o_analog_en [*2];
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("analog on in shutdown");

  property p_shift_msb;
    edge_step && (cnt < `SAPMC_EDGE_LAST)
      |=> (o_serial_data_out.data == $past(q.shreg[`SAPMC_FRAME_BITS-2]));
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("next bit not shifted out");

  property p_tail_zeros;
    (q.phase == sapmc_pkg::SAPMC_SHIFT) && (cnt >= `SAPMC_EDGE_TAIL)
      |-> !o_serial_data_out.data;
  endproperty
  a_tail_zeros: assert property (p_tail_zeros) else $error("trailing bit not zero");

  property p_sample_load;
    o_sample_now && (q.phase == sapmc_pkg::SAPMC_IDLE)
      |=> (q.shreg[`SAPMC_RES_MSB:`SAPMC_RES_LSB] == $past(i_conv_result));
  endproperty
  a_sample_load: assert property (p_sample_load) else $error("result not sampled");

  property p_rise_release;
    cs_rise && (q.phase != sapmc_pkg::SAPMC_IDLE) |=> !o_serial_data_out.oe;
  endproperty
  a_rise_release: assert property (p_rise_release) else $error("output held after rise");

  property p_done_hold;
    (q.phase == sapmc_pkg::SAPMC_DONE) && !i_chip_sel_n
      |=> (q.phase == sapmc_pkg::SAPMC_DONE) && !o_serial_data_out.oe;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("idle-low select restarted");

  property p_valid_frame;
    cs_fall && (q.phase == sapmc_pkg::SAPMC_IDLE) && o_mode_normal && !q.dummy
      |=> o_result_valid;
  endproperty
  a_valid_frame: assert property (p_valid_frame) else $error("powered frame not valid");

  property p_sd_stay;
    !o_mode_normal && (q.phase == sapmc_pkg::SAPMC_IDLE) && i_chip_sel_n
      |=> !o_mode_normal;
  endproperty
  a_sd_stay: assert property (p_sd_stay) else $error("left shutdown with select high");

  property p_count_done;
    (q.phase == sapmc_pkg::SAPMC_DONE) |-> (cnt == `SAPMC_EDGE_SAT);
  endproperty
  a_count_done: assert property (p_count_done) else $error("word done before sixteen");

  c_enter_sd: cover property (cs_rise && (q.phase == sapmc_pkg::SAPMC_SHIFT)
    && (cnt == 5'h05) ##1 !o_mode_normal);
  c_full_word: cover property (edge_step && (cnt == `SAPMC_EDGE_LAST) && q.valid);
  c_late_abort: cover property (cs_rise && (q.phase == sapmc_pkg::SAPMC_SHIFT)
    && (cnt == 5'h0C));
  c_wake: cover property (edge_step && q.from_sd && (cnt == `SAPMC_EDGE_LAST));
  c_glitch: cover property (cs_rise && (q.phase == sapmc_pkg::SAPMC_SHIFT)
    && (cnt < `SAPMC_EDGE_GLITCH));

endmodule
`default_nettype wire

// ---- logic/sapmc_map.svh ----
// sapmc_map.svh: named counts and layout of the serial converter frame
// assumes: included by bare name from the package and design modules
`ifndef SAPMC_MAP_SVH
`define SAPMC_MAP_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define SAPMC_RESULT_BITS 10
`define SAPMC_FRAME_BITS 16
`define SAPMC_LEAD_ZEROS 3'h0
`define SAPMC_TAIL_ZEROS 3'h0
`define SAPMC_CNT_BITS 5
`define SAPMC_RES_LSB 3
`define SAPMC_RES_MSB 12

// ****************************************************************
// falling-edge counts for the mode choice, the data and tail slots and the end of the word
// ****************************************************************
`define SAPMC_EDGE_GLITCH 5'h02
`define SAPMC_EDGE_DATA 5'h03
`define SAPMC_EDGE_TAIL 5'h0D
`define SAPMC_EDGE_MODE 5'h0A
`define SAPMC_EDGE_LAST 5'h0F
`define SAPMC_EDGE_SAT 5'h10
`define SAPMC_CNT_ZERO 5'h00
`define SAPMC_CNT_ONE 5'h01

// ****************************************************************
// reset values
// ****************************************************************
`define SAPMC_RST_MODE sapmc_pkg::SAPMC_SHUTDOWN
`define SAPMC_RST_HIGH 1'h1
`define SAPMC_RST_LOW 1'h0

`endif

// ---- logic/sapmc_pkg.sv ----
// sapmc_pkg: types shared by the frame and power-mode control
// assumes: sapmc_map.svh is on the include path
`include "sapmc_map.svh"

package sapmc_pkg;

  // power mode of the converter
  typedef enum logic {
    SAPMC_SHUTDOWN = 1'b0,
    SAPMC_NORMAL = 1'b1
  } sapmc_mode_t;

  // frame phase
  typedef enum logic [1:0] {
    SAPMC_IDLE = 2'b00,
    SAPMC_SHIFT = 2'b01,
    SAPMC_DONE = 2'b10
  } sapmc_phase_t;

  // serial data output pin: level and enable
  typedef struct packed {
    logic data;
    logic oe;
  } sapmc_sdo_t;

  // state of the edge counter
  typedef struct packed {
    logic [`SAPMC_CNT_BITS-1:0] count;
  } sapmc_cnt_state_t;

  // state of the frame control
  typedef struct packed {
    logic sclk_q;
    logic cs_n_q;
    sapmc_phase_t phase;
    sapmc_mode_t mode;
    logic from_sd;
    logic dummy;
    logic powered;
    logic valid;
    logic [`SAPMC_FRAME_BITS-1:0] shreg;
    logic oe;
  } sapmc_state_t;

endpackage

// ---- logic/sapmc_edge_cnt.sv ----
// sapmc_edge_cnt: saturating count of serial-clock falling edges in a frame
// assumes: step and clear are one-cycle pulses on the core clock
`timescale 1ns/1ps
`default_nettype none
`include "sapmc_map.svh"

module sapmc_edge_cnt #(
  parameter logic [`SAPMC_CNT_BITS-1:0] SAT_EDGES = `SAPMC_EDGE_SAT
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // control
  input wire logic i_clear,
  input wire logic i_step,
  // count
  output logic [`SAPMC_CNT_BITS-1:0] o_count
);

  sapmc_pkg::sapmc_cnt_state_t st_q;
  sapmc_pkg::sapmc_cnt_state_t st_d;

  // ****************************************************************
  // next count
  // ****************************************************************
  // saturating edge count
  always_comb begin
    st_d = st_q;
    if (i_clear) begin
      st_d.count = `SAPMC_CNT_ZERO;
    end else if (i_step && (st_q.count < SAT_EDGES)) begin
      st_d.count = st_q.count + `SAPMC_CNT_ONE;
    end
  end

  // state register
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_count = st_q.count;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_cnt_step;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (i_step && !i_clear && (o_count < SAT_EDGES)) |=> (o_count == $past(o_count) + `SAPMC_CNT_ONE);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("edge count did not step");

  property p_cnt_sat;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    o_count <= SAT_EDGES;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("edge count passed saturation");

endmodule
`default_nettype wire

// ---- verification/sapmc_host_model.sv ----
// sapmc_host_model: behavioural host that frames the link, collects bits
// assumes: bench resolves the data line; core clock is the time base
`timescale 1ns/1ps
`default_nettype none

module sapmc_host_model (
  // clock
  input wire logic i_core_clk,
  // link
  input wire logic i_data_line,
  output logic o_chip_sel_n,
  output logic o_serial_clk,
  // collected slots, first slot highest after shifting
  output logic [15:0] o_word
);
  // ****
  // idle link: select high, clock parked high
  // ****
  initial begin
    o_chip_sel_n = 1'h1;
    o_serial_clk = 1'h1;
    o_word = 16'h0000;
  end

  // wait n edges, drive just after
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic frame(input int n, input int len);
    o_word = 16'h0000;
    tick(1);
    o_chip_sel_n = 1'h0;
    for (int k = 0; k < n; k++) begin
      tick(len);
      // same as capture at the rise
      if (k < 16) o_word = {o_word[14:0], i_data_line};
      o_serial_clk = 1'h0;
      tick(len);
      o_serial_clk = 1'h1;
    end
    tick(2);
  endtask

  task automatic finish_frame(input int gap);
    o_chip_sel_n = 1'h1;
    tick(gap);
  endtask
endmodule

`default_nettype wire

// ---- verification/test_serial_adc_power_mode_control.sv ----
// test_serial_adc_power_mode_control: self-checking bench of the frame control
// assumes: sapmc_pkg and design compiled first, header on include path
`timescale 1ns/1ps
`default_nettype none
`include "sapmc_map.svh"

module test_serial_adc_power_mode_control;
  // ****
  // signals and instances
  // ****
  logic clk;
  logic rst;
  logic cs_n;
  logic sclk;
  logic line;
  logic last_bit = 1'h0;
  logic [`SAPMC_RESULT_BITS-1:0] res_in;
  logic smp;
  logic ana;
  logic mode;
  logic pwr;
  logic vld;
  logic [`SAPMC_CNT_BITS-1:0] cnt;
  logic [15:0] word;
  sapmc_pkg::sapmc_sdo_t sdo;
  int miscompares = 0;
  int n_checks = 0;
  int samples = 0;
  int frames = 0;
  logic e_mode;
  logic e_dummy;
  logic e_pwr;
  int corner[15] = '{20, 20, 1, 12, 16, 5, 0, 12, 16, 9, 10, 2, 15, 14, 3};

  sapmc_ctrl sapmc_ctrl_i (.i_core_clk(clk), .i_sys_rst(rst),
    .i_chip_sel_n(cs_n), .i_serial_clk(sclk), .o_serial_data_out(sdo),
    .i_conv_result(res_in), .o_sample_now(smp), .o_analog_en(ana),
    .o_mode_normal(mode), .o_powered_up(pwr), .o_result_valid(vld),
    .o_edge_count(cnt));
  sapmc_host_model sapmc_host_model_i (.i_core_clk(clk), .i_data_line(line),
    .o_chip_sel_n(cs_n), .o_serial_clk(sclk), .o_word(word));

  // clock, last driven bit, sample pulses
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (sdo.oe) last_bit <= sdo.data;
    if (smp === 1'h1) samples <= samples + 1;
  end
  // released line shows the inverse of the last bit
  assign line = sdo.oe ? sdo.data : ~last_bit;

  // ****
  // tasks and expectations
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // three zeros, result msb first, three zeros
  function automatic logic [15:0] slot_word(input logic [`SAPMC_RESULT_BITS-1:0] r);
    return {3'h0, r, 3'h0};
  endfunction

  // mode after select rises with n falls seen
  function automatic logic next_mode(input int n, input logic prev);
    if (n < 2) return prev;
    return n >= 10;
  endfunction

  // one frame of n falls, then select rise and gap
  task automatic run(input int n, input int len);
    logic [`SAPMC_RESULT_BITS-1:0] r;
    int m;
    r = `SAPMC_RESULT_BITS'($urandom);
    m = (n > 16) ? 16 : n;
    res_in = r;
    fork
      sapmc_host_model_i.frame(n, len);
      begin
        tick(3);
        res_in = ~r;
      end
    join
    frames++;
    check_val(word, slot_word(r) >> (16 - m));
    check_val(16'(cnt), 16'(m));
    check_flag(sdo.oe, n < 16);
    check_flag(ana, 1'h1);
    if (n >= 16) begin
      check_flag(mode, 1'h1);
      check_flag(pwr, 1'h1);
      check_flag(vld, ~e_dummy);
      e_dummy = 1'h0;
      e_pwr = 1'h1;
    end else if (n >= 2 && n < 10) begin
      e_dummy = 1'h1;
      e_pwr = 1'h0;
    end
    e_mode = next_mode(n, e_mode);
    sapmc_host_model_i.finish_frame(3 + $urandom % 4);
    check_flag(sdo.oe, 1'h0);
    check_flag(mode, e_mode);
    check_flag(ana, e_mode);
    check_flag(pwr, e_pwr);
    check_val(16'(samples), 16'(frames));
    $display("test edges=%0d len=%0d done", n, len);
  endtask

  // ****
  // sequence
  // ****
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    res_in = '0;
    e_mode = 1'h0;
    e_dummy = 1'h1;
    e_pwr = 1'h0;
    void'($urandom(4340));
    tick(8);
    rst = 1'h0;
    check_flag(mode, 1'h0);
    check_flag(ana, 1'h0);
    check_flag(sdo.oe, 1'h0);
    foreach (corner[i]) run(corner[i], 2);
    for (int i = 0; i < 40; i++) run($urandom % 21, 2 + $urandom % 2);
    // reset in mid-run brings back shutdown and a dummy
    rst = 1'h1;
    tick(2);
    rst = 1'h0;
    e_mode = 1'h0;
    e_dummy = 1'h1;
    e_pwr = 1'h0;
    check_flag(mode, 1'h0);
    check_flag(pwr, 1'h0);
    run(20, 3);
    run(20, 2);
    summarize();
  end

  // watchdog: about 60 frames of some 60 cycles, with wide margin
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
endmodule

`default_nettype wire
